// file: inc/dic_regs.vh
// Register offsets, field positions and reset values of the DMA interface control bank
`ifndef DIC_REGS_VH
`define DIC_REGS_VH

`define DIC_ADDR_W        7
`define DIC_OFF_CMD       7'h00
`define DIC_OFF_DPSTAT    7'h01
`define DIC_OFF_FUNCT     7'h02
`define DIC_OFF_EVSTAT    7'h03

`define DIC_CMD_DIR       0
`define DIC_CMD_FNR       1
`define DIC_CMD_INV       2
`define DIC_CMD_EN        3
`define DIC_CMD_IEN_LO    4

`define DIC_DP_OFNE       0
`define DIC_DP_IFNE       1
`define DIC_DP_UNDER      2
`define DIC_DP_OVER       3
`define DIC_DP_FULL_LO    4
`define DIC_DP_AFULL      6
`define DIC_DP_IDV        7

`define DIC_FN_PLL        7
`define DIC_FN_CTL_LO     4

`define DIC_CMD_RST       8'h00
`define DIC_FUNCT_RST     8'h00

`endif

// file: verif/dic_ctrl_status_properties.sv
// Port assertions for the control and status bank
`timescale 1ns/1ps
`default_nettype none
module dic_ctrl_status_properties (
    input wire logic       I_REF_CLK,
    input wire logic       I_SRST,
    input wire logic [6:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic       I_REG_WR,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic       I_DEVICE_IRQ_ENABLE,
    input wire logic       I_GLOBAL_EVENT_IRQ_ENABLE,
    input wire logic       I_INPUT_VALID_LINE,
    input wire logic       I_IN_FIFO_FULL,
    input wire logic       O_DIRECTION_SELECT,
    input wire logic       O_INTERFACE_ENABLE,
    input wire logic       O_FIFO_FLUSH,
    input wire logic [3:0] O_USER_FUNCT,
    input wire logic       O_IRQ
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);
    wire logic cmd_wr = I_REG_WR && I_REG_ADDR == 7'h00;
    flush_on_rise_a: assert property (
        cmd_wr && I_REG_WDATA[3] && !O_INTERFACE_ENABLE |=> O_FIFO_FLUSH) else $error("no flush");
    enable_follows_a: assert property (
        cmd_wr |=> O_INTERFACE_ENABLE == $past(I_REG_WDATA[3])) else $error("enable wrong");
    direction_set_a: assert property (
        cmd_wr && I_REG_WDATA[3] |=> O_DIRECTION_SELECT == $past(I_REG_WDATA[0]))
        else $error("direction wrong");
    user_funct_a: assert property (
        I_REG_WR && I_REG_ADDR == 7'h02 |=> O_USER_FUNCT == $past(I_REG_WDATA[3:0]))
        else $error("funct wrong");
    irq_device_gate_a: assert property (
        !I_DEVICE_IRQ_ENABLE |-> !O_IRQ) else $error("irq not gated");
    irq_global_gate_a: assert property (
        !I_GLOBAL_EVENT_IRQ_ENABLE |-> !O_IRQ) else $error("irq not blocked");
    path_status_a: assert property (
        I_REG_ADDR == 7'h01 |=> O_REG_RDATA[7] == $past(I_INPUT_VALID_LINE)
        && O_REG_RDATA[5:4] == {2{$past(I_IN_FIFO_FULL)}}) else $error("status wrong");
    unmapped_zero_a: assert property (
        I_REG_ADDR > 7'h03 |=> O_REG_RDATA == 8'h00) else $error("unmapped not zero");
endmodule
bind dic_ctrl_status dic_ctrl_status_properties u_dic_ctrl_status_properties (.*);
`default_nettype wire

// file: verif/dic_ctrl_status_test.sv
// Directed bench for the control and status bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected %0t %h", $time, a); end end
module dic_ctrl_status_test;
    logic I_REF_CLK = 0, I_SRST = 1, I_REG_WR = 0, I_DEVICE_IRQ_ENABLE = 0;
    logic I_GLOBAL_EVENT_IRQ_ENABLE = 0, O_INVERT_DATA, O_FORCE_NOT_READY, O_IRQ;
    logic I_INPUT_VALID_LINE, I_OUTPUT_VALID_LINE, I_FAR_END_NOT_READY, O_PLL_ENABLE;
    logic I_IN_FIFO_ALMOST_FULL, I_IN_FIFO_FULL, I_IN_FIFO_HAS_DATA, I_OUT_FIFO_HAS_DATA;
    logic O_DIRECTION_SELECT, O_INTERFACE_ENABLE, O_FIFO_FLUSH;
    logic [6:0] I_REG_ADDR = 0;
    logic [7:0] I_REG_WDATA = 0, O_REG_RDATA;
    logic [3:0] I_STAT_POLARITY = 0, I_USER_STAT, O_USER_FUNCT;
    logic [2:0] O_CLOCK_CTRL;
    logic [10:0] scene = 0, lines;
    int n_errors = 0, check_count = 0;
    dic_ctrl_status u_dic_ctrl_status (.*);
    dic_user_equipment u_dic_user_equipment (.i_clk(I_REF_CLK), .i_scene(scene),
        .o_lines(lines));
    assign {I_OUT_FIFO_HAS_DATA, I_IN_FIFO_HAS_DATA, I_IN_FIFO_FULL, I_IN_FIFO_ALMOST_FULL,
        I_FAR_END_NOT_READY, I_OUTPUT_VALID_LINE, I_INPUT_VALID_LINE, I_USER_STAT} = lines;
    always #50 I_REF_CLK = ~I_REF_CLK;
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge I_REF_CLK);
        I_REG_ADDR <= a;
        I_REG_WDATA <= d;
        I_REG_WR <= 1'b1;
        @(posedge I_REF_CLK);
        I_REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge I_REF_CLK);
        I_REG_ADDR <= a;
        @(posedge I_REF_CLK);
        #1 `CHK(O_REG_RDATA, e)
    endtask
    // Four edges cover the partner's register plus the two-edge event path
    task automatic scn(input logic [10:0] v);
        @(posedge I_REF_CLK);
        scene <= v;
        repeat (4) @(posedge I_REF_CLK);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000 n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge I_REF_CLK);
        I_SRST <= 1'b0;
        rd(7'h00, 8'h00);
        rd(7'h7f, 8'h00);
        wr(7'h00, 8'hf7);
        wr(7'h00, 8'hff);
        wr(7'h01, 8'h00);
        rd(7'h00, 8'hff);
        `CHK({O_INVERT_DATA, O_FORCE_NOT_READY, O_DIRECTION_SELECT}, 3'h7)
        wr(7'h02, 8'ha5);
        rd(7'h02, 8'ha5);
        `CHK({O_PLL_ENABLE, O_CLOCK_CTRL, O_USER_FUNCT}, 8'ha5)
        $display("done registers");
        scn(11'h790);
        rd(7'h01, 8'hfb);
        scn(11'h020);
        scn(11'h000);
        rd(7'h01, 8'h0c);
        wr(7'h00, 8'hf7);
        rd(7'h00, 8'hf6);
        wr(7'h00, 8'hff);
        rd(7'h01, 8'h00);
        $display("done data path");
        @(posedge I_REF_CLK);
        I_DEVICE_IRQ_ENABLE <= 1'b1;
        I_GLOBAL_EVENT_IRQ_ENABLE <= 1'b1;
        scn(11'h00f);
        rd(7'h03, 8'hff);
        `CHK(O_IRQ, 1'b1)
        @(posedge I_REF_CLK);
        I_GLOBAL_EVENT_IRQ_ENABLE <= 1'b0;
        rd(7'h03, 8'hff);
        `CHK(O_IRQ, 1'b0)
        @(posedge I_REF_CLK);
        I_GLOBAL_EVENT_IRQ_ENABLE <= 1'b1;
        I_DEVICE_IRQ_ENABLE <= 1'b0;
        rd(7'h03, 8'hff);
        `CHK(O_IRQ, 1'b0)
        wr(7'h00, 8'h0f);
        wr(7'h00, 8'hff);
        rd(7'h03, 8'h0f);
        @(posedge I_REF_CLK);
        I_STAT_POLARITY <= 4'hf;
        scn(11'h000);
        rd(7'h03, 8'hf0);
        $display("done events");
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: verif/dic_user_equipment.sv
// Far-side equipment driving status, valid and FIFO level lines
`timescale 1ns/1ps
`default_nettype none
module dic_user_equipment (
    input  wire logic        i_clk,
    input  wire logic [10:0] i_scene,
    output var  logic [10:0] o_lines
);
    // Lines move just after the edge, as equipment on the shared clock would
    initial o_lines = 11'h000;
    always @(posedge i_clk) begin
        o_lines <= i_scene;
    end
endmodule
`default_nettype wire

// file: verilog/dic_ctrl_status.v
// Command, data path status, function and event status register bank
`timescale 1ns/1ps
`default_nettype none
`include "dic_regs.vh"
module dic_ctrl_status #(
    parameter N_STAT = 4
) (
    input  wire                   I_REF_CLK,
    input  wire                   I_SRST,
    input  wire [`DIC_ADDR_W-1:0] I_REG_ADDR,
    input  wire [7:0]             I_REG_WDATA,
    input  wire                   I_REG_WR,
    output reg  [7:0]             O_REG_RDATA,
    input  wire                   I_DEVICE_IRQ_ENABLE,
    input  wire                   I_GLOBAL_EVENT_IRQ_ENABLE,
    input  wire [N_STAT-1:0]      I_STAT_POLARITY,
    input  wire [N_STAT-1:0]      I_USER_STAT,
    input  wire                   I_INPUT_VALID_LINE,
    input  wire                   I_OUTPUT_VALID_LINE,
    input  wire                   I_FAR_END_NOT_READY,
    input  wire                   I_IN_FIFO_ALMOST_FULL,
    input  wire                   I_IN_FIFO_FULL,
    input  wire                   I_IN_FIFO_HAS_DATA,
    input  wire                   I_OUT_FIFO_HAS_DATA,
    output wire                   O_DIRECTION_SELECT,
    output wire                   O_INVERT_DATA,
    output wire                   O_FORCE_NOT_READY,
    output wire                   O_INTERFACE_ENABLE,
    output reg                    O_FIFO_FLUSH,
    output wire                   O_PLL_ENABLE,
    output wire [2:0]             O_CLOCK_CTRL,
    output wire [3:0]             O_USER_FUNCT,
    output wire                   O_IRQ
);
    reg  [7:0]        cmd_r;
    reg  [7:0]        funct_r;
    reg               overflow_r;
    reg               underflow_r;
    reg               odv_d_r;
    reg  [7:0]        rdata_nxt;
    wire [N_STAT-1:0] sampled;
    wire [N_STAT-1:0] flags;
    wire              wr_cmd;
    wire              en_new;
    wire              en_rise;
    wire              en_fall;

    assign wr_cmd  = I_REG_WR && (I_REG_ADDR == `DIC_OFF_CMD);
    assign en_new  = I_REG_WDATA[`DIC_CMD_EN];
    assign en_rise = wr_cmd && en_new && !cmd_r[`DIC_CMD_EN];
    assign en_fall = wr_cmd && !en_new && cmd_r[`DIC_CMD_EN];

    // Direction is only trusted by software once enable goes high
    always @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            cmd_r   <= `DIC_CMD_RST;
            funct_r <= `DIC_FUNCT_RST;
        end else begin
            if (wr_cmd)
                cmd_r <= I_REG_WDATA;
            // A fall of enable drops the stored direction
            if (en_fall)
                cmd_r[`DIC_CMD_DIR] <= 1'b0;
            if (I_REG_WR && (I_REG_ADDR == `DIC_OFF_FUNCT))
                funct_r <= I_REG_WDATA;
        end
    end

    // Flush pulse on re-enable after a clear
    always @(posedge I_REF_CLK) begin
        if (I_SRST)
            O_FIFO_FLUSH <= 1'b0;
        else
            O_FIFO_FLUSH <= en_rise;
    end

    // Sticky data path errors; only reset or an enable toggle clears them
    always @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            overflow_r  <= 1'b0;
            underflow_r <= 1'b0;
            odv_d_r     <= 1'b0;
        end else begin
            odv_d_r <= I_OUTPUT_VALID_LINE;
            if (I_INPUT_VALID_LINE && I_IN_FIFO_FULL)
                overflow_r <= 1'b1;
            else if (en_rise || en_fall)
                overflow_r <= 1'b0;
            if (odv_d_r && !I_OUTPUT_VALID_LINE && !I_OUT_FIFO_HAS_DATA
                && !I_FAR_END_NOT_READY)
                underflow_r <= 1'b1;
            else if (en_rise || en_fall)
                underflow_r <= 1'b0;
        end
    end

    dic_event_detect #(
        .N (N_STAT)
    ) u_evt (
        .i_clk      (I_REF_CLK),
        .i_rst      (I_SRST),
        .i_stat     (I_USER_STAT),
        .i_polarity (I_STAT_POLARITY),
        .i_bit_en   (cmd_r[`DIC_CMD_IEN_LO +: N_STAT]),
        .o_sampled  (sampled),
        .o_flags    (flags)
    );

    // Global gate leaves flags untouched so the driver can poll others
    assign O_IRQ = I_DEVICE_IRQ_ENABLE && I_GLOBAL_EVENT_IRQ_ENABLE
                 && |(flags & cmd_r[`DIC_CMD_IEN_LO +: N_STAT]);

    assign O_DIRECTION_SELECT = cmd_r[`DIC_CMD_DIR];
    assign O_INVERT_DATA      = cmd_r[`DIC_CMD_INV];
    assign O_FORCE_NOT_READY  = cmd_r[`DIC_CMD_FNR];
    assign O_INTERFACE_ENABLE = cmd_r[`DIC_CMD_EN];
    assign O_PLL_ENABLE       = funct_r[`DIC_FN_PLL];
    assign O_CLOCK_CTRL       = funct_r[`DIC_FN_CTL_LO +: 3];
    assign O_USER_FUNCT       = funct_r[3:0];

    always @* begin
        rdata_nxt = 8'h00;
        case (I_REG_ADDR)
            `DIC_OFF_CMD:    rdata_nxt = cmd_r;
            `DIC_OFF_DPSTAT: begin
                rdata_nxt[`DIC_DP_IDV]   = I_INPUT_VALID_LINE;
                rdata_nxt[`DIC_DP_AFULL] = I_IN_FIFO_ALMOST_FULL;
                rdata_nxt[`DIC_DP_FULL_LO +: 2] = {2{I_IN_FIFO_FULL}};
                rdata_nxt[`DIC_DP_OVER]  = overflow_r;
                rdata_nxt[`DIC_DP_UNDER] = underflow_r;
                rdata_nxt[`DIC_DP_IFNE]  = I_IN_FIFO_HAS_DATA;
                rdata_nxt[`DIC_DP_OFNE]  = I_OUT_FIFO_HAS_DATA;
            end
            `DIC_OFF_FUNCT:  rdata_nxt = funct_r;
            `DIC_OFF_EVSTAT: rdata_nxt = {flags, sampled};
            default:         rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge I_REF_CLK) begin
        if (I_SRST)
            O_REG_RDATA <= 8'h00;
        else
            O_REG_RDATA <= rdata_nxt;
    end
endmodule
`default_nettype wire

// file: verilog/dic_event_detect.v
// Status input sampling and sticky edge event flags
`timescale 1ns/1ps
`default_nettype none
module dic_event_detect #(
    parameter N = 4
) (
    input  wire         i_clk,
    input  wire         i_rst,
    input  wire [N-1:0] i_stat,
    input  wire [N-1:0] i_polarity,
    input  wire [N-1:0] i_bit_en,
    output reg  [N-1:0] o_sampled,
    output reg  [N-1:0] o_flags
);
    reg  [N-1:0] prev_r;
    reg  [N-1:0] en_d_r;
    wire [N-1:0] event_hit;
    wire [N-1:0] en_fall;

    // Event on the selected change between consecutive samples
    assign event_hit = i_polarity & (prev_r & ~o_sampled)
                     | ~i_polarity & (~prev_r & o_sampled);
    assign en_fall = en_d_r & ~i_bit_en;

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_sampled <= {N{1'b0}};
            prev_r    <= {N{1'b0}};
            en_d_r    <= {N{1'b0}};
            o_flags   <= {N{1'b0}};
        end else begin
            o_sampled <= i_stat;
            prev_r    <= o_sampled;
            en_d_r    <= i_bit_en;
            // Set beats clear; clear happens on enable being dropped
            o_flags   <= (o_flags & ~en_fall) | event_hit;
        end
    end
endmodule
`default_nettype wire
